// ===== ess_defines.svh
// Constants for the extended skip, subtract and swap execution block.
// Functional notes
// - skip_if_nonzero skips the next instruction when the byte is not zero; no flags.
// - Every conditional skip instruction here takes three instruction cycles.
// - subtract_to_working stores working register minus byte into the working register.
// - Subtraction writes carry as 0 on negative difference, 1 on zero or positive.
// - Subtraction updates overflow, zero, nibble borrow, carry, sign compare, chained zero.
// - subtract_to_memory writes the difference to memory; working register unchanged.
// - nibble_exchange_in_place swaps the byte nibbles in memory; flags unchanged.
// - nibble_exchange_to_working puts the swapped byte in the working register only.
// - skip_if_zero skips the next instruction when the byte is zero; no flags.
// - copy_then_skip_if_zero copies the byte to working register, skips if zero.
`ifndef ESS_DEFINES_SVH
`define ESS_DEFINES_SVH
`define ESS_DW 8
`define ESS_NW 4
`define ESS_AW 5
`define ESS_MAW 4
`define ESS_MDEPTH 16
`define ESS_PCW 8
`define ESS_OPW 3
`define ESS_FLAGS_W 6
`define ESS_ADDR_WREG 5'h00
`define ESS_ADDR_FLAGS 5'h01
`define ESS_ADDR_PC 5'h02
`define ESS_ADDR_MEM_BIT 4
`define ESS_FLG_C 0
`define ESS_FLG_AC 1
`define ESS_FLG_Z 2
`define ESS_FLG_OV 3
`define ESS_FLG_SC 4
`define ESS_FLG_CZ 5
`define ESS_FLAGS_RST 6'h00
`define ESS_WREG_RST 8'h00
`define ESS_PC_RST 8'h00
`define ESS_PC_STEP 8'h01
`define ESS_PC_SKIP_STEP 8'h02
`define ESS_ZERO_BYTE 8'h00
`define ESS_RDATA_IDLE 8'h00
`define ESS_FLAGS_PAD 2'h0
`endif

// ===== ess_pkg.sv
// Types shared by the execution block modules.
package ess_pkg;
	typedef enum logic [2:0] {
		ESS_OP_SKIP_NZ = 3'h0,
		ESS_OP_SUB_W = 3'h1,
		ESS_OP_SUB_M = 3'h2,
		ESS_OP_SWAP_M = 3'h3,
		ESS_OP_SWAP_W = 3'h4,
		ESS_OP_SKIP_Z = 3'h5,
		ESS_OP_COPY_SKIP_Z = 3'h6,
		ESS_OP_NONE = 3'h7
	} ess_op_t;
	typedef enum logic [1:0] {
		ESS_ST_IDLE = 2'h0,
		ESS_ST_DUMMY = 2'h1,
		ESS_ST_TAIL = 2'h2
	} ess_state_t;
endpackage

// ===== ess_alu_if.sv
// Operand and result bundle between the sequencer and the arithmetic unit.
`timescale 1ns/1ps
`include "ess_defines.svh"
interface ess_alu_if;
	logic [`ESS_DW-1:0] acc;
	logic [`ESS_DW-1:0] mem;
	logic [`ESS_DW-1:0] diff;
	logic [`ESS_DW-1:0] swapped;
	logic [`ESS_FLAGS_W-1:0] flags;
	modport core (output acc, output mem, input diff, input swapped, input flags);
	modport alu (input acc, input mem, output diff, output swapped, output flags);
endinterface

// ===== ess_alu.sv
// Combinational subtractor with status flags and nibble exchanger.
`timescale 1ns/1ps
`include "ess_defines.svh"
module ess_alu (
	ess_alu_if.alu bus
);
	wire [`ESS_DW:0] full_diff;
	wire [`ESS_NW:0] half_diff;
	wire overflow;
	assign full_diff = {1'b0, bus.acc} - {1'b0, bus.mem};
	assign half_diff = {1'b0, bus.acc[`ESS_NW-1:0]} - {1'b0, bus.mem[`ESS_NW-1:0]};
	assign bus.diff = full_diff[`ESS_DW-1:0];
	// Signed overflow when operand signs differ and the result sign leaves the minuend's.
	assign overflow = (bus.acc[`ESS_DW-1] != bus.mem[`ESS_DW-1]) && (full_diff[`ESS_DW-1] != bus.acc[`ESS_DW-1]);
	assign bus.flags[`ESS_FLG_C] = ~full_diff[`ESS_DW];
	assign bus.flags[`ESS_FLG_AC] = ~half_diff[`ESS_NW];
	assign bus.flags[`ESS_FLG_Z] = (full_diff[`ESS_DW-1:0] == `ESS_ZERO_BYTE);
	assign bus.flags[`ESS_FLG_OV] = overflow;
	assign bus.flags[`ESS_FLG_SC] = overflow ^ full_diff[`ESS_DW-1];
	// With no incoming borrow the chained zero equals the plain zero.
	assign bus.flags[`ESS_FLG_CZ] = (full_diff[`ESS_DW-1:0] == `ESS_ZERO_BYTE);
	assign bus.swapped = {bus.mem[`ESS_NW-1:0], bus.mem[`ESS_DW-1:`ESS_NW]};
endmodule

// ===== ess_dmem.sv
// Data memory with one write port and two asynchronous read ports.
`timescale 1ns/1ps
`include "ess_defines.svh"
module ess_dmem (
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [`ESS_MAW-1:0] waddr_i,
	input wire logic [`ESS_DW-1:0] wdata_i,
	input wire logic [`ESS_MAW-1:0] raddr_a_i,
	output logic [`ESS_DW-1:0] rdata_a_o,
	input wire logic [`ESS_MAW-1:0] raddr_b_i,
	output logic [`ESS_DW-1:0] rdata_b_o
);
	logic [`ESS_DW-1:0] mem_q [`ESS_MDEPTH];
	// Contents are left unreset, as software is expected to initialise them.
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem_q[waddr_i] <= wdata_i;
		end
	end
	assign rdata_a_o = mem_q[raddr_a_i];
	assign rdata_b_o = mem_q[raddr_b_i];
endmodule

// ===== ess_exec.sv
// Sequencer for the extended skip, subtract and nibble swap instructions.
`timescale 1ns/1ps
`include "ess_defines.svh"
module ess_exec
	import ess_pkg::*;
(
	input wire logic REF_CLK_I,
	input wire logic RST_I,
	input wire logic INSTR_VALID_I,
	input wire logic [`ESS_OPW-1:0] INSTR_OP_I,
	input wire logic [`ESS_MAW-1:0] INSTR_ADDR_I,
	input wire logic [`ESS_AW-1:0] REG_ADDR_I,
	input wire logic [`ESS_DW-1:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [`ESS_DW-1:0] REG_RDATA_O,
	output logic READY_O,
	output logic SKIP_O,
	output logic [`ESS_PCW-1:0] PC_O,
	output logic [`ESS_DW-1:0] WREG_O,
	output logic [`ESS_FLAGS_W-1:0] FLAGS_O
);
	ess_state_t state_q;
	ess_state_t state_d;
	logic ready_q;
	logic skip_q;
	logic skip_d;
	logic skip_out_q;
	logic [`ESS_PCW-1:0] pc_q;
	logic [`ESS_PCW-1:0] pc_d;
	logic [`ESS_DW-1:0] wreg_q;
	logic [`ESS_DW-1:0] wreg_d;
	logic [`ESS_FLAGS_W-1:0] flags_q;
	logic [`ESS_FLAGS_W-1:0] flags_d;
	logic [`ESS_DW-1:0] rdata_q;
	logic [`ESS_DW-1:0] rdata_d;

	ess_op_t op;
	wire issue;
	wire is_sub;
	wire is_skip;
	wire byte_zero;
	wire skip_cond;
	wire core_we;
	wire [`ESS_DW-1:0] core_wdata;
	wire wreg_load;
	wire [`ESS_DW-1:0] wreg_val;
	wire flags_load;
	wire sel_wreg;
	wire sel_flags;
	wire sel_pc;
	wire sel_mem;
	wire sw_wreg_wr;
	wire sw_flags_wr;
	wire sw_mem_wr;
	wire mem_we;
	wire [`ESS_MAW-1:0] mem_waddr;
	wire [`ESS_DW-1:0] mem_wdata;
	wire [`ESS_DW-1:0] read_mux;
	logic [`ESS_DW-1:0] mem_byte;
	logic [`ESS_DW-1:0] bus_mem_byte;

	ess_alu_if alu_bus();

	ess_alu u_alu (
		.bus(alu_bus.alu)
	);

	ess_dmem u_dmem (
		.clk_i(REF_CLK_I),
		.we_i(mem_we),
		.waddr_i(mem_waddr),
		.wdata_i(mem_wdata),
		.raddr_a_i(INSTR_ADDR_I),
		.rdata_a_o(mem_byte),
		.raddr_b_i(REG_ADDR_I[`ESS_MAW-1:0]),
		.rdata_b_o(bus_mem_byte)
	);

	// Instruction decode. An instruction is only taken while the sequencer is idle.
	assign op = ess_op_t'(INSTR_OP_I);
	assign issue = INSTR_VALID_I && ready_q;
	assign is_sub = (op == ESS_OP_SUB_W) || (op == ESS_OP_SUB_M);
	assign is_skip = (op == ESS_OP_SKIP_NZ) || (op == ESS_OP_SKIP_Z) || (op == ESS_OP_COPY_SKIP_Z);
	assign byte_zero = (mem_byte == `ESS_ZERO_BYTE);
	assign skip_cond = (op == ESS_OP_SKIP_NZ) ? !byte_zero : byte_zero;

	assign alu_bus.acc = wreg_q;
	assign alu_bus.mem = mem_byte;

	// The core writes memory only for the subtract-to-memory and in-place swap instructions.
	assign core_we = issue && ((op == ESS_OP_SUB_M) || (op == ESS_OP_SWAP_M));
	assign core_wdata = (op == ESS_OP_SUB_M) ? alu_bus.diff : alu_bus.swapped;
	assign wreg_load = issue && ((op == ESS_OP_SUB_W) || (op == ESS_OP_SWAP_W) || (op == ESS_OP_COPY_SKIP_Z));
	assign wreg_val = (op == ESS_OP_SUB_W) ? alu_bus.diff :
		(op == ESS_OP_SWAP_W) ? alu_bus.swapped : mem_byte;
	assign flags_load = issue && is_sub;

	// Register port decode. The core wins a same-cycle collision, so a software write is dropped then.
	assign sel_wreg = (REG_ADDR_I == `ESS_ADDR_WREG);
	assign sel_flags = (REG_ADDR_I == `ESS_ADDR_FLAGS);
	assign sel_pc = (REG_ADDR_I == `ESS_ADDR_PC);
	assign sel_mem = REG_ADDR_I[`ESS_ADDR_MEM_BIT];
	assign sw_wreg_wr = REG_WR_I && sel_wreg && !wreg_load;
	assign sw_flags_wr = REG_WR_I && sel_flags && !flags_load;
	assign sw_mem_wr = REG_WR_I && sel_mem && !core_we;
	assign mem_we = core_we || sw_mem_wr;
	assign mem_waddr = core_we ? INSTR_ADDR_I : REG_ADDR_I[`ESS_MAW-1:0];
	assign mem_wdata = core_we ? core_wdata : REG_WDATA_I;
	assign read_mux = sel_mem ? bus_mem_byte :
		sel_wreg ? wreg_q :
		sel_flags ? {`ESS_FLAGS_PAD, flags_q} :
		sel_pc ? pc_q : `ESS_RDATA_IDLE;

	assign wreg_d = wreg_load ? wreg_val : (sw_wreg_wr ? REG_WDATA_I : wreg_q);
	assign flags_d = flags_load ? alu_bus.flags : (sw_flags_wr ? REG_WDATA_I[`ESS_FLAGS_W-1:0] : flags_q);
	assign rdata_d = REG_RD_I ? read_mux : `ESS_RDATA_IDLE;
	assign skip_d = (issue && is_skip) ? skip_cond : skip_q;

	// A skip runs execute, dummy and tail cycles; the tail is the no-operation for a skipped word.
	always_comb begin
		state_d = state_q;
		case (state_q)
			ESS_ST_IDLE: begin
				if (issue && is_skip) begin
					state_d = ESS_ST_DUMMY;
				end
			end
			ESS_ST_DUMMY: begin
				state_d = ESS_ST_TAIL;
			end
			ESS_ST_TAIL: begin
				state_d = ESS_ST_IDLE;
			end
			default: begin
				state_d = ESS_ST_IDLE;
			end
		endcase
	end

	// The program counter steps past the skipped word only when the tail cycle ends.
	always_comb begin
		pc_d = pc_q;
		if (issue && !is_skip) begin
			pc_d = pc_q + `ESS_PC_STEP;
		end else if (state_q == ESS_ST_TAIL) begin
			pc_d = pc_q + (skip_q ? `ESS_PC_SKIP_STEP : `ESS_PC_STEP);
		end
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_q <= ESS_ST_IDLE;
			ready_q <= 1'b1;
			skip_q <= 1'b0;
			skip_out_q <= 1'b0;
			pc_q <= `ESS_PC_RST;
			wreg_q <= `ESS_WREG_RST;
			flags_q <= `ESS_FLAGS_RST;
			rdata_q <= `ESS_RDATA_IDLE;
		end else begin
			state_q <= state_d;
			ready_q <= (state_d == ESS_ST_IDLE);
			skip_q <= skip_d;
			skip_out_q <= (state_d == ESS_ST_TAIL) && skip_d;
			pc_q <= pc_d;
			wreg_q <= wreg_d;
			flags_q <= flags_d;
			rdata_q <= rdata_d;
		end
	end

	assign REG_RDATA_O = rdata_q;
	assign READY_O = ready_q;
	assign SKIP_O = skip_out_q;
	assign PC_O = pc_q;
	assign WREG_O = wreg_q;
	assign FLAGS_O = flags_q;

	// Reference values computed independently of the arithmetic unit.
	wire [`ESS_DW-1:0] ref_swap;
	wire [`ESS_DW-1:0] ref_diff;
	wire ref_no_borrow;
	assign ref_swap = {mem_byte[`ESS_NW-1:0], mem_byte[`ESS_DW-1:`ESS_NW]};
	assign ref_diff = wreg_q - mem_byte;
	assign ref_no_borrow = (wreg_q >= mem_byte);
	// A nine-bit difference of sign-extended operands gives signed overflow and the true sign directly.
	wire ref_nib_ok;
	wire [`ESS_DW:0] ref_sdiff;
	wire ref_ov;
	assign ref_nib_ok = (wreg_q[`ESS_NW-1:0] >= mem_byte[`ESS_NW-1:0]);
	assign ref_sdiff = {wreg_q[`ESS_DW-1], wreg_q} - {mem_byte[`ESS_DW-1], mem_byte};
	assign ref_ov = (ref_sdiff[`ESS_DW] != ref_sdiff[`ESS_DW-1]);

	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (RST_I);
	// Checks that a whole register keeps its value leave out a software write in their first cycle only, which may legally land beside them.

	AST_SNZ_SKIP: assert property (
		issue && (op == ESS_OP_SKIP_NZ) && !REG_WR_I |->
		##2 (SKIP_O == !$past(byte_zero, 2)) && (FLAGS_O == $past(FLAGS_O, 2))
	) else $error("skip_if_nonzero took the wrong skip decision or touched flags");

	AST_SKIP_THREE: assert property (
		issue && is_skip |=> !READY_O [*2] ##1 READY_O
	) else $error("conditional skip did not take three cycles");

	AST_SUB_W: assert property (
		issue && (op == ESS_OP_SUB_W) |-> ##1 (WREG_O == $past(ref_diff)) && READY_O
	) else $error("subtract_to_working result wrong");

	AST_SUB_CARRY: assert property (
		issue && is_sub |=> FLAGS_O[`ESS_FLG_C] == $past(ref_no_borrow)
	) else $error("subtraction carry flag wrong");

	AST_SUB_FLAGS: assert property (
		issue && is_sub |=> (FLAGS_O[`ESS_FLG_Z] == ($past(ref_diff) == `ESS_ZERO_BYTE)) &&
			(FLAGS_O[`ESS_FLG_CZ] == FLAGS_O[`ESS_FLG_Z]) &&
			(FLAGS_O[`ESS_FLG_SC] == (FLAGS_O[`ESS_FLG_OV] ^ $past(ref_diff[`ESS_DW-1])))
	) else $error("subtraction zero, chained zero or sign compare flag wrong");

	AST_SUB_M: assert property (
		issue && (op == ESS_OP_SUB_M) && !REG_WR_I |-> mem_we && (mem_wdata == ref_diff) && (mem_waddr == INSTR_ADDR_I)
			##1 (WREG_O == $past(WREG_O))
	) else $error("subtract_to_memory wrote wrong value or changed the working register");

	AST_SWAP_M: assert property (
		issue && (op == ESS_OP_SWAP_M) && !REG_WR_I |-> mem_we && (mem_wdata == ref_swap)
			##1 (FLAGS_O == $past(FLAGS_O))
	) else $error("in-place nibble exchange wrong or flags changed");

	AST_SWAP_W: assert property (
		issue && (op == ESS_OP_SWAP_W) && !REG_WR_I |-> !mem_we ##1 (WREG_O == $past(ref_swap)) &&
			(FLAGS_O == $past(FLAGS_O))
	) else $error("nibble exchange to working register wrong");

	AST_SZ_SKIP: assert property (
		issue && (op == ESS_OP_SKIP_Z) && !REG_WR_I |->
		##2 (SKIP_O == $past(byte_zero, 2)) && (FLAGS_O == $past(FLAGS_O, 2))
	) else $error("skip_if_zero took the wrong skip decision or touched flags");

	AST_SZA: assert property (
		issue && (op == ESS_OP_COPY_SKIP_Z) |=> (WREG_O == $past(mem_byte)) ##1 (SKIP_O == $past(byte_zero, 2))
	) else $error("copy_then_skip_if_zero copy or skip wrong");

	AST_SKIP_PC: assert property (
		(state_q == ESS_ST_TAIL) |=> (PC_O == $past(PC_O) + ($past(skip_q) ? `ESS_PC_SKIP_STEP : `ESS_PC_STEP))
			&& !SKIP_O
	) else $error("program counter did not step past the tail cycle");

	AST_SKIP_NO_WRITE: assert property (
		(state_q != ESS_ST_IDLE) |-> !core_we && !wreg_load && !flags_load
	) else $error("core wrote state during a dummy or skipped cycle");

	AST_SUB_NIB_OV: assert property (
		issue && is_sub |=> (FLAGS_O[`ESS_FLG_AC] == $past(ref_nib_ok)) &&
			(FLAGS_O[`ESS_FLG_OV] == $past(ref_ov)) && (FLAGS_O[`ESS_FLG_SC] == $past(ref_sdiff[`ESS_DW]))
	) else $error("subtraction nibble borrow, overflow or sign compare flag wrong");

	AST_SUB_STEP: assert property (
		issue && is_sub |=> READY_O && (PC_O == $past(PC_O) + `ESS_PC_STEP)
	) else $error("subtraction did not finish in one cycle");

	AST_SUB_W_NO_MEM: assert property (
		issue && (op == ESS_OP_SUB_W) && !REG_WR_I |-> !mem_we
	) else $error("subtract_to_working wrote data memory");

	AST_SWAP_STEP: assert property (
		issue && ((op == ESS_OP_SWAP_M) || (op == ESS_OP_SWAP_W)) |=>
			READY_O && (PC_O == $past(PC_O) + `ESS_PC_STEP)
	) else $error("nibble exchange did not finish in one cycle");

	AST_SWAP_M_KEEP_WREG: assert property (
		issue && (op == ESS_OP_SWAP_M) && !REG_WR_I |=> WREG_O == $past(WREG_O)
	) else $error("in-place nibble exchange changed the working register");

	AST_SKIP_KEEP_WREG: assert property (
		issue && ((op == ESS_OP_SKIP_NZ) || (op == ESS_OP_SKIP_Z)) && !REG_WR_I |=> WREG_O == $past(WREG_O)
	) else $error("plain skip changed the working register");

	AST_SKIP_NO_MEM: assert property (
		issue && is_skip && !REG_WR_I |-> !mem_we
			##1 (FLAGS_O == $past(FLAGS_O))
	) else $error("conditional skip wrote memory or flags");

	AST_DUMMY_QUIET: assert property (
		(state_q == ESS_ST_DUMMY) |-> !READY_O && !SKIP_O
	) else $error("dummy cycle reported ready or a skip");

	AST_TAIL_NOP: assert property (
		(state_q == ESS_ST_TAIL) && !REG_WR_I |-> !mem_we
			##1 (WREG_O == $past(WREG_O)) && (FLAGS_O == $past(FLAGS_O))
	) else $error("no-operation cycle changed a register or memory");

	AST_SKIP_ONE_PULSE: assert property (
		SKIP_O |=> !SKIP_O
	) else $error("skip marker stood longer than one cycle");

	// Covers show that the bench reaches taken and untaken skips, borrows and back-to-back swaps.
	COV_SNZ_TAKEN: cover property (issue && (op == ESS_OP_SKIP_NZ) && !byte_zero ##2 SKIP_O);
	COV_SZA_NOT_TAKEN: cover property (issue && (op == ESS_OP_COPY_SKIP_Z) && !byte_zero);
	COV_SUB_M_BORROW: cover property (issue && (op == ESS_OP_SUB_M) && !ref_no_borrow);
	COV_SWAP_BACK_TO_BACK: cover property (issue && (op == ESS_OP_SWAP_W) ##1 issue && (op == ESS_OP_SWAP_M));
	COV_SZ_TAKEN: cover property (issue && (op == ESS_OP_SKIP_Z) && byte_zero ##2 SKIP_O);
endmodule

// ===== tb_top.sv
// Self-checking bench for the extended skip, subtract and nibble swap sequencer.
`timescale 1ns/1ps
`include "ess_defines.svh"
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin failures++; $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top
	import ess_pkg::*;
;
	logic REF_CLK_I, RST_I, INSTR_VALID_I, REG_WR_I, REG_RD_I, READY_O, SKIP_O;
	logic [`ESS_OPW-1:0] INSTR_OP_I;
	logic [`ESS_MAW-1:0] INSTR_ADDR_I;
	logic [`ESS_AW-1:0] REG_ADDR_I;
	logic [`ESS_DW-1:0] REG_WDATA_I, REG_RDATA_O, WREG_O;
	logic [`ESS_PCW-1:0] PC_O;
	logic [`ESS_FLAGS_W-1:0] FLAGS_O;
	int failures = 0;
	int checked = 0;
	logic [7:0] q[$];
	logic rd_seen = 1'b0;
	logic [7:0] exp_rd = 8'h00;
	logic [7:0] m [0:15];
	logic [7:0] w = 8'h00;
	logic [7:0] pc = 8'h00;
	logic [5:0] f = 6'h00;
	logic [31:0] seed = 32'h5de34ee1;
	logic [7:0] pa [0:5] = '{8'h00, 8'h80, 8'h7f, 8'h10, 8'h55, 8'hff};
	logic [7:0] pb [0:5] = '{8'h01, 8'h01, 8'hff, 8'h01, 8'h55, 8'h7f};
	ess_exec dut (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .INSTR_VALID_I(INSTR_VALID_I), .INSTR_OP_I(INSTR_OP_I),
		.INSTR_ADDR_I(INSTR_ADDR_I), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I),
		.REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .READY_O(READY_O), .SKIP_O(SKIP_O), .PC_O(PC_O),
		.WREG_O(WREG_O), .FLAGS_O(FLAGS_O));
	initial begin
		REF_CLK_I = 1'b0;
		forever #50 REF_CLK_I = ~REF_CLK_I;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		xs = s ^ (s << 5);
	endfunction
	function automatic logic [5:0] flg(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] d;
		logic ov;
		d = a - b;
		ov = (a[7] ^ b[7]) & (d[7] ^ a[7]);
		flg = 6'h00;
		flg[`ESS_FLG_C] = (a >= b);
		flg[`ESS_FLG_AC] = (a[3:0] >= b[3:0]);
		flg[`ESS_FLG_Z] = (d == 8'h00);
		flg[`ESS_FLG_OV] = ov;
		flg[`ESS_FLG_SC] = ov ^ d[7];
		flg[`ESS_FLG_CZ] = (d == 8'h00);
	endfunction
	// Read results appear only in the cycle after the strobe, so the monitor lags the strobe by one cycle.
	always @(negedge REF_CLK_I) begin
		if (rd_seen) begin
			exp_rd = q.pop_front();
			`CHK(REG_RDATA_O, exp_rd)
		end
		rd_seen = REG_RD_I;
	end
	task automatic idle();
		@(posedge REF_CLK_I);
		INSTR_VALID_I <= 1'b0;
		REG_WR_I <= 1'b0;
		REG_RD_I <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge REF_CLK_I);
		INSTR_VALID_I <= 1'b0;
		REG_RD_I <= 1'b0;
		REG_WR_I <= 1'b1;
		REG_ADDR_I <= a;
		REG_WDATA_I <= d;
		if (a == `ESS_ADDR_WREG) w = d;
		else if (a == `ESS_ADDR_FLAGS) f = d[5:0];
		else if (a[`ESS_ADDR_MEM_BIT]) m[a[3:0]] = d;
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		@(posedge REF_CLK_I);
		INSTR_VALID_I <= 1'b0;
		REG_WR_I <= 1'b0;
		REG_RD_I <= 1'b1;
		REG_ADDR_I <= a;
		q.push_back(e);
	endtask
	task automatic chk_ports();
		idle();
		@(negedge REF_CLK_I);
		`CHK(WREG_O, w)
		`CHK(FLAGS_O, f)
		`CHK(PC_O, pc)
		`CHK(READY_O, 1'b1)
	endtask
	task automatic ex(input logic [2:0] op, input logic [3:0] a);
		logic [7:0] v;
		logic isk, sk;
		v = m[a];
		isk = (op == ESS_OP_SKIP_NZ) || (op == ESS_OP_SKIP_Z) || (op == ESS_OP_COPY_SKIP_Z);
		sk = (op == ESS_OP_SKIP_NZ) ? (v != 8'h00) : (v == 8'h00);
		@(posedge REF_CLK_I);
		INSTR_VALID_I <= 1'b1;
		INSTR_OP_I <= op;
		INSTR_ADDR_I <= a;
		REG_WR_I <= 1'b0;
		REG_RD_I <= 1'b0;
		case (op)
			ESS_OP_SUB_W: begin f = flg(w, v); w = w - v; end
			ESS_OP_SUB_M: begin f = flg(w, v); m[a] = w - v; end
			ESS_OP_SWAP_M: m[a] = {v[3:0], v[7:4]};
			ESS_OP_SWAP_W: w = {v[3:0], v[7:4]};
			ESS_OP_COPY_SKIP_Z: w = v;
			default: ;
		endcase
		pc = pc + ((isk && sk) ? 8'h02 : 8'h01);
		if (isk) begin
			// A subtract offered while busy must be ignored; a later memory read would expose it.
			@(posedge REF_CLK_I);
			INSTR_OP_I <= ESS_OP_SUB_M;
			@(negedge REF_CLK_I);
			`CHK(READY_O, 1'b0)
			`CHK(WREG_O, w)
			@(posedge REF_CLK_I);
			INSTR_VALID_I <= 1'b0;
			@(negedge REF_CLK_I);
			`CHK(READY_O, 1'b0)
			`CHK(SKIP_O, sk)
			@(negedge REF_CLK_I);
			`CHK(READY_O, 1'b1)
			`CHK(SKIP_O, 1'b0)
			`CHK(PC_O, pc)
			`CHK(FLAGS_O, f)
		end
	endtask
	task automatic close_out();
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#2000000;
		failures++;
		close_out();
	end
	initial begin
		RST_I = 1'b1;
		INSTR_VALID_I = 1'b0;
		INSTR_OP_I = 3'h7;
		INSTR_ADDR_I = 4'h0;
		REG_ADDR_I = 5'h00;
		REG_WDATA_I = 8'h00;
		REG_WR_I = 1'b0;
		REG_RD_I = 1'b0;
		repeat (20) @(posedge REF_CLK_I);
		RST_I <= 1'b0;
		rd(`ESS_ADDR_WREG, 8'h00);
		rd(`ESS_ADDR_FLAGS, 8'h00);
		rd(`ESS_ADDR_PC, 8'h00);
		wr(`ESS_ADDR_PC, 8'h33);
		wr(5'h05, 8'h44);
		rd(`ESS_ADDR_PC, 8'h00);
		rd(5'h05, 8'h00);
		for (int i = 0; i < 16; i++) begin
			seed = xs(seed);
			wr(5'h10 + i, (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : seed[7:0]);
		end
		for (int k = 0; k < 6; k++) begin
			for (int op = 1; op < 3; op++) begin
				wr(`ESS_ADDR_WREG, pa[k]);
				wr(5'h13, pb[k]);
				ex(op, 4'h3);
				rd(5'h13, m[3]);
				chk_ports();
			end
		end
		for (int op = 0; op < 7; op++) begin
			for (int a = 0; a < 2; a++) begin
				if (op == 0 || op > 4) begin
					wr(`ESS_ADDR_WREG, 8'h5a);
					ex(op, a);
					rd(5'h10 + a, m[a]);
				end
			end
		end
		wr(5'h14, 8'ha5);
		ex(ESS_OP_SWAP_M, 4'h4);
		ex(ESS_OP_SWAP_W, 4'h4);
		ex(ESS_OP_NONE, 4'h4);
		rd(5'h14, m[4]);
		chk_ports();
		repeat (80) begin
			seed = xs(seed);
			if (seed[31]) wr(`ESS_ADDR_WREG, seed[15:8]);
			if (seed[30]) wr(`ESS_ADDR_FLAGS, seed[23:16]);
			if (seed[29]) wr(5'h10 + seed[6:3], 8'h00);
			ex(seed[2:0], seed[6:3]);
			if (seed[7]) chk_ports();
		end
		chk_ports();
		for (int i = 0; i < 16; i++) rd(5'h10 + i, m[i]);
		rd(`ESS_ADDR_WREG, w);
		rd(`ESS_ADDR_FLAGS, {`ESS_FLAGS_PAD, f});
		rd(`ESS_ADDR_PC, pc);
		idle();
		repeat (3) @(posedge REF_CLK_I);
		close_out();
	end
endmodule
